// >>> pfs_pin_mux.sv
// Pin function select: routes upper port B, port C and port D pins between
// general-purpose I/O and peripheral functions, and tracks the test access
// port reset behaviour. Assumes pins outside pass through separate pad cells;
// select and clock-enable bits arrive as plain ports from system logic.

// Operation
// - B6: serial rx, I2C data, clock in
// - Clock input needs clock-generation enable too
// - B7: serial tx or I2C clock
// - C2: analog A2 or converter A reference
// - C4: analog B0 or comparator B input3
// - C6: analog B2 or converter B reference
// - No test reset pin; held high
// - Power-on reset forces TAP reset state
// - Five TMS-high test clock edges reset TAP
// - Four ports: 8, 8, 6, 4 pins
module pfs_pin_mux
    import pfs_pkg::*;
#(
    parameter int PORTA_W = PFS_PORTA_W,
    parameter int PORTB_W = PFS_PORTB_W,
    parameter int PORTC_W = PFS_PORTC_W,
    parameter int PORTD_W = PFS_PORTD_W
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic arst_n,
    // Configuration
    input wire logic [PFS_SEL_W-1:0] pin_peripheral_select_reg,
    input wire logic sel_load,
    input wire logic clkgen_ext_clk_en,
    // Pin inputs (pad side)
    input wire logic portb_pin6_in,
    input wire logic portb_pin7_in,
    input wire logic tck_pin,
    input wire logic tms_pin,
    // Peripheral outputs toward pins
    input wire logic serial_tx_out,
    input wire logic i2c_sda_out_en,
    input wire logic i2c_scl_out_en,
    input wire logic tap_tdo,
    input wire logic tap_tdo_en,
    // Pin drive (pad side)
    output logic portb_pin6_out,
    output logic portb_pin6_oe,
    output logic portb_pin7_out,
    output logic portb_pin7_oe,
    output logic portd_tdo_out,
    output logic portd_tdo_oe,
    // Peripheral inputs from pins
    output logic serial_rx_in,
    output logic i2c_sda_in,
    output logic i2c_scl_in,
    output logic external_clock_in,
    // Analog switch enables
    output logic analog_a_input2,
    output logic converter_a_high_ref,
    output logic analog_b_input0,
    output logic comparator_b_input3,
    output logic analog_b_input2,
    output logic converter_b_high_ref,
    // Port status
    output logic [PFS_PORTS*8-1:0] port_width_map,
    output logic [PORTC_W-1:0] portc_gpio_mask,
    // Test access port state
    output logic tap_in_reset,
    output logic [2:0] tap_state
);

    // ----------------------------------------------------------------
    // Select register
    // ----------------------------------------------------------------
    logic [PFS_SEL_W-1:0] sel_q; // Held pin function selects
    logic [1:0] fn_b6, fn_b7, fn_c2, fn_c4, fn_c6; // Per-pin fields

    // Selects default to GPIO at reset
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            sel_q <= PFS_SEL_RST;
        end else if (sel_load) begin
            sel_q <= pin_peripheral_select_reg;
        end
    end

    assign fn_b6 = sel_q[PFS_B6_LSB +: 2];
    assign fn_b7 = sel_q[PFS_B7_LSB +: 2];
    assign fn_c2 = sel_q[PFS_C2_LSB +: 2];
    assign fn_c4 = sel_q[PFS_C4_LSB +: 2];
    assign fn_c6 = sel_q[PFS_C6_LSB +: 2];

    // ----------------------------------------------------------------
    // Pin input synchronisers for port B
    // ----------------------------------------------------------------
    logic [1:0] b6_sync_q; // Two-flop chain for B6
    logic [1:0] b7_sync_q; // Two-flop chain for B7

    // Pins are asynchronous; idle high like an open-drain bus
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            b6_sync_q <= 2'h3;
            b7_sync_q <= 2'h3;
        end else begin
            b6_sync_q <= {b6_sync_q[0], portb_pin6_in};
            b7_sync_q <= {b7_sync_q[0], portb_pin7_in};
        end
    end

    // ----------------------------------------------------------------
    // Peripheral inputs, registered
    // ----------------------------------------------------------------
    // Deselected inputs hold idle: serial and I2C idle high, clock low.
    // The clock path costs three cycles of latency; this mux is meant
    // for its selection, a real clock input would bypass through a cell.
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            serial_rx_in <= 1'b1;
            i2c_sda_in <= 1'b1;
            i2c_scl_in <= 1'b1;
            external_clock_in <= 1'b0;
        end else begin
            serial_rx_in <= (fn_b6 == PFS_FN_ALT1) ? b6_sync_q[1] : 1'b1;
            i2c_sda_in <= (fn_b6 == PFS_FN_ALT2) ? b6_sync_q[1] : 1'b1;
            i2c_scl_in <= (fn_b7 == PFS_FN_ALT2) ? b7_sync_q[1] : 1'b1;
            // Clock input only with clock-generation enable as well
            external_clock_in <= (fn_b6 == PFS_FN_ALT3) && clkgen_ext_clk_en
                                 ? b6_sync_q[1] : 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // Pin drive toward port B
    // ----------------------------------------------------------------
    // B6 only drives low for I2C data; GPIO drive lives in the port block
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            portb_pin6_out <= 1'b0;
            portb_pin6_oe <= 1'b0;
            portb_pin7_out <= 1'b0;
            portb_pin7_oe <= 1'b0;
        end else begin
            portb_pin6_out <= 1'b0;
            portb_pin6_oe <= (fn_b6 == PFS_FN_ALT2) && i2c_sda_out_en;
            // B7: serial transmit push-pull, or I2C clock open-drain
            if (fn_b7 == PFS_FN_ALT1) begin
                portb_pin7_out <= serial_tx_out;
                portb_pin7_oe <= 1'b1;
            end else if (fn_b7 == PFS_FN_ALT2) begin
                portb_pin7_out <= 1'b0;
                portb_pin7_oe <= i2c_scl_out_en;
            end else begin
                portb_pin7_out <= 1'b0;
                portb_pin7_oe <= 1'b0;
            end
        end
    end

    // ----------------------------------------------------------------
    // Analog switch enables on port C
    // ----------------------------------------------------------------
    // Switches change on the same edge, no break-before-make: all open by default
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            analog_a_input2 <= 1'b0;
            converter_a_high_ref <= 1'b0;
            analog_b_input0 <= 1'b0;
            comparator_b_input3 <= 1'b0;
            analog_b_input2 <= 1'b0;
            converter_b_high_ref <= 1'b0;
        end else begin
            analog_a_input2 <= (fn_c2 == PFS_FN_ALT1);
            converter_a_high_ref <= (fn_c2 == PFS_FN_ALT2);
            analog_b_input0 <= (fn_c4 == PFS_FN_ALT1);
            comparator_b_input3 <= (fn_c4 == PFS_FN_ALT2);
            analog_b_input2 <= (fn_c6 == PFS_FN_ALT1);
            converter_b_high_ref <= (fn_c6 == PFS_FN_ALT2);
        end
    end

    // Port C pins still in GPIO: bit 5 follows the C6 select, bits 0, 1 and 3 always GPIO
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            portc_gpio_mask <= '1;
        end else begin
            portc_gpio_mask <= '1;
            portc_gpio_mask[2] <= (fn_c2 == PFS_FN_GPIO) || (fn_c2 == PFS_FN_ALT3);
            portc_gpio_mask[4] <= (fn_c4 == PFS_FN_GPIO) || (fn_c4 == PFS_FN_ALT3);
            portc_gpio_mask[5] <= (fn_c6 == PFS_FN_GPIO) || (fn_c6 == PFS_FN_ALT3);
        end
    end

    // Port widths A..D, one byte each, fixed
    assign port_width_map = {8'(PORTD_W), 8'(PORTC_W), 8'(PORTB_W), 8'(PORTA_W)};

    // ----------------------------------------------------------------
    // Test access port tracker
    // ----------------------------------------------------------------
    pfs_tck_if tck_ev ();

    pfs_tck_sync u_tck_sync (
        .mclk(mclk),
        .arst_n(arst_n),
        .tck_pin(tck_pin),
        .tms_pin(tms_pin),
        .ev(tck_ev)
    );

    pfs_tap_e tap_q; // Controller state
    logic [2:0] tms_hi_q; // Consecutive TMS-high edges

    // Count TMS-high test clock edges, saturating at five
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            tms_hi_q <= 3'h0;
        end else if (tck_ev.tck_rise) begin
            if (!tck_ev.tms) begin
                tms_hi_q <= 3'h0;
            end else if (tms_hi_q != PFS_TAP_RESET_EDGES) begin
                tms_hi_q <= tms_hi_q + 3'h1;
            end
        end
    end

    // Reduced state walk; soft reset forced on the fifth TMS-high edge
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            tap_q <= PFS_TAP_RESET;
        end else if (!tck_ev.trst_n) begin
            tap_q <= PFS_TAP_RESET;
        end else if (tck_ev.tck_rise) begin
            if (tck_ev.tms && tms_hi_q == PFS_TAP_RESET_EDGES - 3'h1) begin
                tap_q <= PFS_TAP_RESET;
            end else begin
                case (tap_q)
                    PFS_TAP_RESET: tap_q <= tck_ev.tms ? PFS_TAP_RESET : PFS_TAP_IDLE;
                    PFS_TAP_IDLE: tap_q <= tck_ev.tms ? PFS_TAP_SEL_DR : PFS_TAP_IDLE;
                    PFS_TAP_SEL_DR: tap_q <= tck_ev.tms ? PFS_TAP_SEL_DR : PFS_TAP_SHIFT;
                    PFS_TAP_SHIFT: tap_q <= tck_ev.tms ? PFS_TAP_EXIT : PFS_TAP_SHIFT;
                    PFS_TAP_EXIT: tap_q <= tck_ev.tms ? PFS_TAP_UPDATE : PFS_TAP_SHIFT;
                    PFS_TAP_UPDATE: tap_q <= tck_ev.tms ? PFS_TAP_SEL_DR : PFS_TAP_IDLE;
                    default: tap_q <= PFS_TAP_RESET;
                endcase
            end
        end
    end

    assign tap_state = tap_q;
    assign tap_in_reset = (tap_q == PFS_TAP_RESET);

    // Port D carries test data out, enabled only in the shift state
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            portd_tdo_out <= 1'b0;
            portd_tdo_oe <= 1'b0;
        end else begin
            portd_tdo_out <= tap_tdo;
            portd_tdo_oe <= tap_tdo_en && (tap_q == PFS_TAP_SHIFT);
        end
    end

endmodule

// >>> pfs_pkg.sv
// Package for the pin function select block: select encodings, port widths,
// test access port state codes and reset values.
// Assumes a single system clock domain; no bus, selects arrive as plain ports.
package pfs_pkg;

    // ----------------------------------------------------------------
    // Port widths
    // ----------------------------------------------------------------
    localparam int PFS_PORTA_W = 8;
    localparam int PFS_PORTB_W = 8;
    localparam int PFS_PORTC_W = 6;
    localparam int PFS_PORTD_W = 4;
    localparam int PFS_PORTS = 4;

    // ----------------------------------------------------------------
    // Select field layout of pin_peripheral_select_reg
    // ----------------------------------------------------------------
    localparam int PFS_SEL_W = 10;
    localparam int PFS_B6_LSB = 0;
    localparam int PFS_B7_LSB = 2;
    localparam int PFS_C2_LSB = 4;
    localparam int PFS_C4_LSB = 6;
    localparam int PFS_C6_LSB = 8;
    localparam logic [PFS_SEL_W-1:0] PFS_SEL_RST = 10'h000;

    // Per-pin function codes (two bits each)
    localparam logic [1:0] PFS_FN_GPIO = 2'h0;
    localparam logic [1:0] PFS_FN_ALT1 = 2'h1;
    localparam logic [1:0] PFS_FN_ALT2 = 2'h2;
    localparam logic [1:0] PFS_FN_ALT3 = 2'h3;

    // ----------------------------------------------------------------
    // Test access port
    // ----------------------------------------------------------------
    localparam logic [2:0] PFS_TAP_RESET_EDGES = 3'h5;
    localparam logic PFS_TRST_INACTIVE = 1'b1;

    // Gray codes along reset -> idle -> shift path
    typedef enum logic [2:0] {
        PFS_TAP_RESET = 3'h0,
        PFS_TAP_IDLE = 3'h1,
        PFS_TAP_SEL_DR = 3'h3,
        PFS_TAP_SHIFT = 3'h2,
        PFS_TAP_EXIT = 3'h6,
        PFS_TAP_UPDATE = 3'h7
    } pfs_tap_e;

endpackage

// >>> pfs_tck_if.sv
// Interface carrying synchronised test clock events from the test pin synchroniser
// into the main block. Assumes both ends run on mclk.
interface pfs_tck_if;
    logic tck_rise; // One-cycle pulse per rising test clock edge
    logic tms; // Synchronised mode select level
    logic trst_n; // Test reset, held inactive

    modport src (output tck_rise, output tms, output trst_n);
    modport dst (input tck_rise, input tms, input trst_n);
endinterface

// >>> pfs_tck_sync.sv
// Synchroniser for the test pins: two flops per pin, then edge detection.
// Assumes test clock is much slower than mclk (at least 3 mclk per phase).
module pfs_tck_sync
    import pfs_pkg::*;
(
    // Clock and reset
    input wire logic mclk,
    input wire logic arst_n,
    // Raw pins
    input wire logic tck_pin,
    input wire logic tms_pin,
    // Events out
    pfs_tck_if.src ev
);

    logic [1:0] tck_sync_q; // Two-flop chain for test clock
    logic [1:0] tms_sync_q; // Two-flop chain for mode select
    logic tck_prev_q; // Previous synced clock, for edge detect

    // Two-flop synchronisers; first stage read only by the second
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            tck_sync_q <= 2'h0;
            tms_sync_q <= 2'h3;
        end else begin
            tck_sync_q <= {tck_sync_q[0], tck_pin};
            tms_sync_q <= {tms_sync_q[0], tms_pin};
        end
    end

    // Edge detect looks only at the second stage
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            tck_prev_q <= 1'b0;
        end else begin
            tck_prev_q <= tck_sync_q[1];
        end
    end

    assign ev.tck_rise = tck_sync_q[1] & ~tck_prev_q;
    assign ev.tms = tms_sync_q[1];
    // No test reset pin: tied inactive inside the package
    assign ev.trst_n = PFS_TRST_INACTIVE;

endmodule

// >>> pfs_pin_mux_sva.sv
// Checker for the pin function select block: select latency, idle levels,
// test port reset. Assumes it is bound to pfs_pin_mux and sees its ports only.
module pfs_pin_mux_sva
    import pfs_pkg::*;
(
    // Clock and reset
    input wire logic mclk,
    input wire logic arst_n,
    // Selects and raw test pins
    input wire logic [PFS_SEL_W-1:0] pin_peripheral_select_reg,
    input wire logic sel_load,
    input wire logic tck_pin,
    input wire logic tms_pin,
    // Watched outputs
    input wire logic serial_rx_in,
    input wire logic i2c_sda_in,
    input wire logic external_clock_in,
    input wire logic portb_pin7_oe,
    input wire logic analog_a_input2,
    input wire logic [PFS_PORTS*8-1:0] port_width_map,
    input wire logic [2:0] tap_state
);
    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!arst_n);
    logic [PFS_SEL_W-1:0] s; // Short alias of the select word
    logic tck_q; // Raw test clock one cycle back
    logic [2:0] hi_q; // Rises in a row with mode select high
    assign s = pin_peripheral_select_reg;
    // Counts raw pins, so the bound below must absorb the sync delay
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            tck_q <= 1'b0;
            hi_q <= 3'h0;
        end else begin
            tck_q <= tck_pin;
            if (tck_pin && !tck_q) begin
                hi_q <= !tms_pin ? 3'h0 : (hi_q == 3'h5 ? hi_q : hi_q + 3'h1);
            end
        end
    end
    sequence five_s;
        $rose(hi_q == 3'h5);
    endsequence
    // A load that is not overtaken by another load on the next edge;
    // back-to-back loads are legal; each reaches the pins for one cycle, and the last one stays
    sequence load_s(cond);
        sel_load && cond ##1 !sel_load;
    endsequence
    // ----------------------------------------------------------------
    // Properties
    // ----------------------------------------------------------------
    chk_rx_idle: assert property (load_s(s[1:0] != 2'h1) |=> serial_rx_in)
        else $error("receive input not idle");
    chk_sda_idle: assert property (load_s(s[1:0] != 2'h2) |=> i2c_sda_in)
        else $error("data input not idle");
    chk_external_clock_in_code: assert property (load_s(s[1:0] != 2'h3) |=> !external_clock_in)
        else $error("clock input leaks");
    chk_tx_drive: assert property (load_s(s[3:2] == 2'h1) |=> portb_pin7_oe)
        else $error("transmit pin not driven");
    chk_c2_input: assert property (load_s(s[5:4] == 2'h1) |=> analog_a_input2)
        else $error("analog switch not on");
    chk_tap_por: assert property ($rose(arst_n) |-> tap_state == PFS_TAP_RESET)
        else $error("tap not reset by power-on");
    chk_five_rises: assert property (five_s |-> ##[1:6] tap_state == PFS_TAP_RESET)
        else $error("tap not reset by five rises");
    chk_width_map: assert property (port_width_map == 32'h04060808)
        else $error("port width map wrong");
endmodule

bind pfs_pin_mux pfs_pin_mux_sva u_sva (.mclk, .arst_n, .pin_peripheral_select_reg,
    .sel_load, .tck_pin, .tms_pin, .serial_rx_in, .i2c_sda_in, .external_clock_in,
    .portb_pin7_oe, .analog_a_input2, .port_width_map, .tap_state);

// >>> pfs_tester.sv
// Test probe model: bursts of test clock rises at a fixed mode select.
// Assumes a one-cycle go; the clock stands low between bursts.
module pfs_tester (
    // Clock
    input wire logic mclk,
    // Burst request
    input wire logic go,
    input wire logic tms_lvl,
    input wire logic [2:0] n_rise,
    // Test pins and status
    output logic tck_pin,
    output logic tms_pin,
    output logic busy
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        tck_pin = 1'b0;
        tms_pin = 1'b1;
        busy = 1'b0;
    end
    // Phases of 8 cycles keep well above the sync's minimum
    always begin
        @(posedge mclk);
        if (go) begin
            busy <= 1'b1;
            tms_pin <= tms_lvl;
            repeat (n_rise) begin
                repeat (8) @(posedge mclk);
                tck_pin <= 1'b1;
                repeat (8) @(posedge mclk);
                tck_pin <= 1'b0;
            end
            repeat (8) @(posedge mclk);
            busy <= 1'b0;
        end
    end
endmodule

// >>> testbench.sv
// Bench for the pin function select block: random loads with corner codes,
// reset defaults and test port reset. Assumes a 50 MHz mclk.
module testbench
    import pfs_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic mclk, arst_n, ld, en, p6, p7, tx, da, cl, tdo, tde, go, tml, busy, tck, tms;
    logic [2:0] nr, st;
    logic [9:0] sel;
    logic p6o, p6e, p7o, p7e, tdoo, tdoe, rx, sda, scl, ck, a2, ra, b0, cb, b2, rb, inr;
    logic [31:0] wmap;
    logic [5:0] mask;
    logic [19:0] got; // Same order as expect_pins
    integer seed;
    int failures, n_checks, cyc;
    assign got = {mask, rx, sda, scl, ck, p6o, p6e, p7o, p7e, a2, ra, b0, cb, b2, rb};
    pfs_pin_mux dut (.mclk(mclk), .arst_n(arst_n), .pin_peripheral_select_reg(sel),
        .sel_load(ld), .clkgen_ext_clk_en(en), .portb_pin6_in(p6), .portb_pin7_in(p7),
        .tck_pin(tck), .tms_pin(tms), .serial_tx_out(tx), .i2c_sda_out_en(da),
        .i2c_scl_out_en(cl), .tap_tdo(tdo), .tap_tdo_en(tde), .portb_pin6_out(p6o),
        .portb_pin6_oe(p6e), .portb_pin7_out(p7o), .portb_pin7_oe(p7e),
        .portd_tdo_out(tdoo), .portd_tdo_oe(tdoe), .serial_rx_in(rx), .i2c_sda_in(sda),
        .i2c_scl_in(scl), .external_clock_in(ck), .analog_a_input2(a2),
        .converter_a_high_ref(ra), .analog_b_input0(b0), .comparator_b_input3(cb),
        .analog_b_input2(b2), .converter_b_high_ref(rb), .port_width_map(wmap),
        .portc_gpio_mask(mask), .tap_in_reset(inr), .tap_state(st));
    pfs_tester tester (.mclk(mclk), .go(go), .tms_lvl(tml), .n_rise(nr), .tck_pin(tck),
        .tms_pin(tms), .busy(busy));
    // ----------------------------------------------------------------
    // Checking
    // ----------------------------------------------------------------
    task automatic chk_vec(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            failures++;
            $display("unexpected %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic final_report();
        if (failures == 0 && n_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // Expected outputs; v is {clock enable, pin6, pin7, tx, sda pull, scl pull}
    function automatic logic [19:0] expect_pins(input logic [9:0] s, input logic [5:0] v);
        logic [1:0] b6, b7, c2, c4, c6;
        {c6, c4, c2, b7, b6} = s;
        return {c6[0] == c6[1], c4[0] == c4[1], 1'b1, c2[0] == c2[1], 2'h3,
            b6 == 2'h1 ? v[4] : 1'b1, b6 == 2'h2 ? v[4] : 1'b1, b7 == 2'h2 ? v[3] : 1'b1,
            b6 == 2'h3 && v[5] ? v[4] : 1'b0, 1'b0, b6 == 2'h2 && v[1], b7 == 2'h1 && v[2],
            b7 == 2'h1 || (b7 == 2'h2 && v[0]), c2 == 2'h1, c2 == 2'h2, c4 == 2'h1,
            c4 == 2'h2, c6 == 2'h1, c6 == 2'h2};
    endfunction
    // Odd passes load a junk word first, so back-to-back loads are covered
    task automatic apply(input int i);
        logic [9:0] fs;
        logic [19:0] e;
        @(posedge mclk);
        #2;
        fs = i < 4 ? {5{i[1:0]}} : 10'($random(seed));
        sel = i[0] ? 10'($random(seed)) : fs;
        {en, p6, p7, tx, da, cl, tdo, tde} = 8'($random(seed));
        ld = 1'b1;
        if (i[0]) begin
            @(posedge mclk);
            #2;
            sel = fs;
        end
        @(posedge mclk);
        #2;
        ld = 1'b0;
        sel = 10'($random(seed)); // Not loaded, so it must be ignored
        repeat (4) @(posedge mclk);
        #1;
        e = expect_pins(fs, {en, p6, p7, tx, da, cl});
        chk_vec("port c", 32'(e & 20'hFC03F), 32'(got & 20'hFC03F));
        chk_vec("port b", 32'(e & 20'h03FC0), 32'(got & 20'h03FC0));
    endtask
    task automatic tap_run(input logic t, input logic [2:0] n, input logic [3:0] e);
        int k;
        @(posedge mclk);
        #2;
        {tml, nr, go} = {t, n, 1'b1};
        @(posedge mclk);
        #2;
        go = 1'b0;
        for (k = 0; k < 400 && busy; k++) @(posedge mclk);
        #1;
        chk_vec("tap state", 32'(e), 32'({inr, st}));
    endtask
    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end
    // Hang guard: the run needs under a thousand cycles
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 3000) begin
            failures++;
            final_report();
        end
    end
    initial begin
        seed = 32'hc3bc;
        {arst_n, ld, en, p6, p7, tx, da, cl, tdo, tde, go, tml, nr, sel} = '0;
        repeat (12) @(posedge mclk);
        #2;
        arst_n = 1'b1;
        @(posedge mclk);
        #1;
        chk_vec("reset pins", 32'(expect_pins('0, '0)), 32'(got));
        chk_vec("tap at power-on", 32'h8, 32'({inr, st}));
        chk_vec("port widths", 32'h04060808, wmap);
        for (int i = 0; i < 40; i++) apply(i);
        tap_run(1'b0, 3'h1, 4'h1);
        tap_run(1'b1, 3'h5, 4'h8);
        tap_run(1'b0, 3'h1, 4'h1);
        tap_run(1'b1, 3'h1, 4'h3);
        tap_run(1'b0, 3'h1, 4'h2);
        // In the shift state port D must pass test data and drive
        @(posedge mclk);
        #2;
        tdo = 1'($random(seed));
        tde = 1'b1;
        repeat (2) @(posedge mclk);
        #1;
        chk_vec("test data out", 32'({tdo, 1'b1}), 32'({tdoo, tdoe}));
        // Leave shift through exit and update, then forced soft reset
        tap_run(1'b1, 3'h5, 4'h8);
        @(posedge mclk);
        #2;
        arst_n = 1'b0;
        @(posedge mclk);
        #2;
        arst_n = 1'b1;
        @(posedge mclk);
        #1;
        chk_vec("tap after reset", 32'h8, 32'({inr, st}));
        chk_vec("pins after reset", 32'(expect_pins('0, {en, p6, p7, tx, da, cl})), 32'(got));
        final_report();
    end
endmodule
